// ### hw/swt_channel_top.sv
// Square wave timer channel with AXI4-Lite registers
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "swt_params.svh"
// Overview of operation
// - Invert wave output on each channel event while output enabled and output mode clear
// - At zero reload counter, raise event, toggle if output enabled and output mode clear
// - Wave output low after reset
// - Gate bit zero stops unit clock
// - Clock zero is fclk over two^field
// - Mode bits 15:14 pick prescaled clock
// - Mode register holds documented fields
// - Half period is reload plus one ticks
// - Output mode clear: toggle on own event
// - Enable set: timer drives, level writes ignored
// - Count down; start bit zero: no start event
module swt_channel_top (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output swt_pkg::swt_resp_type     s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output swt_pkg::swt_resp_type     s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic                      wave_out_pin,
    output logic                      chan_irq_event
);
    import swt_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]      clk_en;
        swt_word_type    prescale;
        swt_word_type    mode;
        swt_word_type    reload;
        logic [2:0]      out_ctrl;
        logic            running;
        logic            start_pend;
        logic            event_seen;
        logic            wave;
        logic            irq;
        logic            aw_got;
        logic [7:0]      aw_addr;
        logic            w_got;
        logic [31:0]     w_data;
        logic [3:0]      w_strb;
        logic            bvalid;
        swt_resp_type    bresp;
        logic            rvalid;
        logic [31:0]     rdata;
        swt_resp_type    rresp;
    } swt_state_type;
    swt_state_type s_q;
    swt_state_type s_d;

    swt_tick_if      tk ();
    logic [3:0]      prs_sel [4];
    logic            load;
    logic            expired;
    logic            cnt_tick;
    logic [15:0]     count;
    logic            evt;
    logic            do_write;
    swt_clk_sel_type csel;

    // ------------------------------------------------------------
    // Clock gating and prescaler
    // ------------------------------------------------------------
    assign tk.gate = s_q.clk_en[`SWT_GATE_BIT];
    for (genvar i = 0; i < 4; i++) begin : g_sel
        assign prs_sel[i] = s_q.prescale[4*i +: 4];
    end

    swt_prescaler #(.DIV_W(16)) u_pre (
        .aclk    (aclk),
        .aresetn (aresetn),
        .prs_sel (prs_sel),
        .tk      (tk)
    );

    // Map the two-bit operation clock field to a tick line
    function automatic logic pick_tick(input swt_clk_sel_type c, input logic [3:0] t);
        case (c)
            SWT_CLK0: return t[0];
            SWT_CLK2: return t[2];
            SWT_CLK1: return t[1];
            SWT_CLK3: return t[3];
            default:  return 1'b0;
        endcase
    endfunction

    assign csel     = swt_clk_sel_type'(s_q.mode[`SWT_CKS_HI:`SWT_CKS_LO]);
    assign cnt_tick = s_q.running && pick_tick(csel, tk.tick);
    assign load     = s_q.start_pend;

    swt_counter #(.CNT_W(16)) u_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (load),
        .tick    (cnt_tick),
        .reload  (s_q.reload),
        .expired (expired),
        .count   (count)
    );

    // Channel event: every expiry, or start when the start option is set
    assign evt = expired || (load && s_q.mode[`SWT_MD_START_BIT]);

    assign do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;

    // Byte-lane merge of a write into a 16-bit register
    function automatic swt_word_type merge16(input swt_word_type old, input logic [31:0] d,
                                             input logic [3:0] st);
        swt_word_type r;
        r = old;
        if (st[0]) r[7:0]  = d[7:0];
        if (st[1]) r[15:8] = d[15:8];
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.start_pend = 1'b0;
        s_d.irq = evt;
        if (s_q.start_pend) begin
            s_d.running = 1'b1;
        end
        if (!tk.gate) begin
            s_d.running = 1'b0;
        end
        // Master mode toggles on own event while timer output enabled
        if (evt && s_q.out_ctrl[`SWT_OC_ENABLE_BIT] && !s_q.out_ctrl[`SWT_OC_MODE_BIT]) begin
            s_d.wave = !s_q.wave;
        end
        // Write channel
        if (s_axi_awvalid && !s_q.aw_got) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got) begin
            s_d.w_got  = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = `SWT_RESP_OKAY;
            case ({s_q.aw_addr[7:2], 2'b00})
                `SWT_OFF_CLK_EN: begin
                    if (s_q.w_strb[0]) s_d.clk_en = s_q.w_data[7:0];
                end
                `SWT_OFF_PRESCALE: s_d.prescale = merge16(s_q.prescale, s_q.w_data, s_q.w_strb);
                `SWT_OFF_MODE: begin
                    s_d.mode = merge16(s_q.mode, s_q.w_data, s_q.w_strb) & `SWT_MODE_WMASK;
                end
                `SWT_OFF_RELOAD: s_d.reload = merge16(s_q.reload, s_q.w_data, s_q.w_strb);
                `SWT_OFF_OUT_CTRL: begin
                    if (s_q.w_strb[0]) begin
                        s_d.out_ctrl[1:0] = s_q.w_data[1:0];
                        // Level write only takes while timer output disabled
                        if (!s_q.out_ctrl[`SWT_OC_ENABLE_BIT]) begin
                            s_d.wave = s_q.w_data[`SWT_OC_LEVEL_BIT];
                        end
                    end
                end
                `SWT_OFF_START: begin
                    if (s_q.w_strb[0] && tk.gate) begin
                        s_d.start_pend = s_q.w_data[0];
                        s_d.running    = s_q.running && s_q.w_data[0];
                    end
                end
                `SWT_OFF_STATUS: begin
                    if (s_q.w_strb[0] && s_q.w_data[`SWT_ST_EVENT_BIT]) begin
                        s_d.event_seen = 1'b0;
                    end
                end
                `SWT_OFF_COUNT: s_d.bresp = `SWT_RESP_OKAY;
                default: s_d.bresp = `SWT_RESP_SLVERR;
            endcase
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // Event sets after any clear so set wins
        if (evt) begin
            s_d.event_seen = 1'b1;
        end
        // Read channel
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = `SWT_RESP_OKAY;
            s_d.rdata  = '0;
            case ({s_axi_araddr[7:2], 2'b00})
                `SWT_OFF_CLK_EN:   s_d.rdata[7:0]  = s_q.clk_en;
                `SWT_OFF_PRESCALE: s_d.rdata[15:0] = s_q.prescale;
                `SWT_OFF_MODE:     s_d.rdata[15:0] = s_q.mode;
                `SWT_OFF_RELOAD:   s_d.rdata[15:0] = s_q.reload;
                `SWT_OFF_OUT_CTRL: s_d.rdata[2:0]  = {s_q.wave, s_q.out_ctrl[1:0]};
                `SWT_OFF_START:    s_d.rdata[0]    = s_q.running;
                `SWT_OFF_STATUS:   s_d.rdata[2:0]  = {s_q.wave, s_q.event_seen, s_q.running};
                `SWT_OFF_COUNT:    s_d.rdata[15:0] = count;
                default:           s_d.rresp       = `SWT_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready  = !s_q.aw_got;
    assign s_axi_wready   = !s_q.w_got;
    assign s_axi_bvalid   = s_q.bvalid;
    assign s_axi_bresp    = s_q.bresp;
    assign s_axi_arready  = !s_q.rvalid;
    assign s_axi_rvalid   = s_q.rvalid;
    assign s_axi_rdata    = s_q.rdata;
    assign s_axi_rresp    = s_q.rresp;
    assign wave_out_pin   = s_q.wave;
    assign chan_irq_event = s_q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence expire_s;
        expired && s_q.out_ctrl[`SWT_OC_ENABLE_BIT] && !s_q.out_ctrl[`SWT_OC_MODE_BIT];
    endsequence

    wave_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        expire_s |=> wave_out_pin != $past(wave_out_pin))
        else $error("wave did not toggle on event");
    irq_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        expired |=> chan_irq_event)
        else $error("event not raised at expiry");
    wave_reset_a: assert property (@(posedge aclk)
        !aresetn |=> !wave_out_pin)
        else $error("wave not low after reset");
    gate_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !tk.gate |-> tk.tick == 4'h0)
        else $error("ticks while unit clock gated");
    clock_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.running && csel == SWT_CLK2 |-> cnt_tick == tk.tick[2])
        else $error("wrong operation clock selected");
    mode_fixed_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.mode[13] == 1'b0 && s_q.mode[5:4] == 2'b00)
        else $error("fixed mode bits not zero");
    no_start_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
        load && !s_q.mode[`SWT_MD_START_BIT] |=> !chan_irq_event)
        else $error("event at start with option clear");
    start_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        load |=> count == $past(s_q.reload) && s_q.running)
        else $error("start did not load counter");
    level_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.out_ctrl[`SWT_OC_ENABLE_BIT] && !evt |=> wave_out_pin == $past(wave_out_pin))
        else $error("wave changed without event while enabled");
endmodule
`default_nettype wire

// ### hw/swt_counter.sv
// Down-counter with reload for the channel
`timescale 1ns/1ps
`default_nettype none
module swt_counter #(
    parameter int CNT_W = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             load,
    input  wire logic             tick,
    input  wire logic [CNT_W-1:0] reload,
    output logic                  expired,
    output logic      [CNT_W-1:0] count
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } swt_cnt_state_type;
    swt_cnt_state_type s_q;
    swt_cnt_state_type s_d;

    initial begin
        if (CNT_W < 2 || CNT_W > 16) $error("swt_counter: CNT_W out of range");
    end

    assign expired = tick && !load && s_q.cnt == '0;
    assign count   = s_q.cnt;

    always_comb begin
        s_d = s_q;
        if (load || expired) begin
            s_d.cnt = reload;
        end else if (tick) begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    reload_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        expired |=> count == $past(reload))
        else $error("counter not reloaded at zero");
endmodule
`default_nettype wire

// ### hw/swt_prescaler.sv
// Prescaler making the four operation clock ticks
`timescale 1ns/1ps
`default_nettype none
`include "swt_params.svh"
module swt_prescaler #(
    parameter int DIV_W = 16
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [3:0] prs_sel [4],
    swt_tick_if.src         tk
);
    import swt_pkg::*;
    typedef struct packed {
        logic [DIV_W-1:0] div;
    } swt_pre_state_type;
    swt_pre_state_type s_q;
    swt_pre_state_type s_d;
    logic [DIV_W:0] nxt;

    initial begin
        if (DIV_W != 16) $error("swt_prescaler: DIV_W must be 16");
    end

    // Tick when all bits below the selected power are ones
    function automatic logic tick_at(input logic [DIV_W-1:0] d, input logic [3:0] p);
        logic [DIV_W-1:0] m;
        m = (DIV_W'(1) << p) - DIV_W'(1);
        return (d & m) == m;
    endfunction

    always_comb begin
        nxt = {1'b0, s_q.div} + (DIV_W+1)'(1);
        s_d = s_q;
        if (tk.gate) begin
            s_d.div = nxt[DIV_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    for (genvar i = 0; i < 4; i++) begin : g_tick
        assign tk.tick[i] = tk.gate & tick_at(s_q.div, prs_sel[i]);
    end

    tick_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tk.gate && prs_sel[0] == 4'h1 && tk.tick[0] ##1 tk.gate |-> !tk.tick[0])
        else $error("prescaled clock zero ticks too often");
endmodule
`default_nettype wire

// ### include/swt_params.svh
// Register offsets, field positions and response codes for the square wave timer channel
`ifndef SWT_PARAMS_SVH
`define SWT_PARAMS_SVH
`define SWT_OFF_CLK_EN      8'h00
`define SWT_OFF_PRESCALE    8'h04
`define SWT_OFF_MODE        8'h08
`define SWT_OFF_RELOAD      8'h0c
`define SWT_OFF_OUT_CTRL    8'h10
`define SWT_OFF_START       8'h14
`define SWT_OFF_STATUS      8'h18
`define SWT_OFF_COUNT       8'h1c
`define SWT_GATE_BIT        0
`define SWT_PRS_MSB         3
`define SWT_CKS_HI          15
`define SWT_CKS_LO          14
`define SWT_CCS_BIT         12
`define SWT_SPLIT_BIT       11
`define SWT_STS_MSB         10
`define SWT_STS_LSB         8
`define SWT_CIS_MSB         7
`define SWT_CIS_LSB         6
`define SWT_MD_MSB          3
`define SWT_MD_START_BIT    0
`define SWT_MODE_WMASK      16'hdfcf
`define SWT_OC_ENABLE_BIT   0
`define SWT_OC_MODE_BIT     1
`define SWT_OC_LEVEL_BIT    2
`define SWT_ST_RUN_BIT      0
`define SWT_ST_EVENT_BIT    1
`define SWT_ST_OUT_BIT      2
`define SWT_MD_INTERVAL     3'h0
`define SWT_RESP_OKAY       2'h0
`define SWT_RESP_SLVERR     2'h2
`endif

// ### include/swt_pkg.sv
// Types shared by the square wave timer channel
package swt_pkg;
    typedef logic [15:0] swt_word_type;
    typedef logic [1:0]  swt_resp_type;
    typedef enum logic [1:0] {
        SWT_CLK0,
        SWT_CLK2,
        SWT_CLK1,
        SWT_CLK3
    } swt_clk_sel_type;
endpackage

// ### include/swt_tick_if.sv
// Count clock ticks passed from the prescaler to the channel
`timescale 1ns/1ps
`default_nettype none
interface swt_tick_if;
    logic [3:0] tick;
    logic       gate;
    modport src (output tick, input gate);
    modport dst (input tick, output gate);
endinterface
`default_nettype wire

// ### testbench/swt_wave_load.sv
// Model of the load on the square wave pin: measures half periods and counts edges
`timescale 1ns/1ps
`default_nettype none
module swt_wave_load (
    input  wire logic aclk,
    input  wire logic wave_in,
    input  wire logic irq_in,
    output var  int   half_len,
    output var  int   toggles,
    output var  int   events
);
    logic last_q;
    int   run_q;
    initial begin
        last_q = 1'b0;
        run_q = 0;
        half_len = 0;
        toggles = 0;
        events = 0;
    end
    // --------------------------------
    // Cycles between successive toggles
    // --------------------------------
    always @(posedge aclk) begin
        run_q <= run_q + 1;
        // Unknown pin level before reset is not a toggle
        if ((wave_in ^ last_q) === 1'b1) begin
            half_len <= run_q + 1;
            run_q <= 0;
            toggles <= toggles + 1;
        end
        if (irq_in === 1'b1) begin
            events <= events + 1;
        end
        last_q <= wave_in;
    end
endmodule
`default_nettype wire

// ### testbench/test_square_wave_timer_channel.sv
// Self-checking bench for the square wave timer channel
`timescale 1ns/1ps
`default_nettype none
`include "swt_params.svh"
module test_square_wave_timer_channel;
    import swt_pkg::*;
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    logic [7:0]   awaddr = 8'h00;
    logic [7:0]   araddr = 8'h00;
    logic [31:0]  wdata = 32'h0;
    logic [3:0]   wstrb = 4'h0;
    logic         awvalid = 1'b0;
    logic         wvalid = 1'b0;
    logic         bready = 1'b0;
    logic         arvalid = 1'b0;
    logic         rready = 1'b0;
    logic         awready, wready, bvalid, arready, rvalid, pin, irq;
    logic [31:0]  rdata, rd_data;
    swt_resp_type bresp, rresp, rd_resp;
    int           half_len, toggles, events;
    int           n_mismatch = 0;
    int           check_count = 0;
    logic [15:0]  seed = 16'h000f;
    // Clock zero divides by two, clock one by one, clocks two and three by four and eight
    localparam logic [15:0] prs_cfg = 16'h3201;

    always #12.5 aclk = ~aclk;

    swt_channel_top u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wave_out_pin(pin), .chan_irq_event(irq)
    );
    swt_wave_load u_load (
        .aclk(aclk), .wave_in(pin), .irq_in(irq),
        .half_len(half_len), .toggles(toggles), .events(events)
    );

    // --------------------------------
    // Bus tasks and expectations
    // --------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Mode bits 15:14 pick clock 0, 2, 1, 3
    function automatic int exp_half(input logic [1:0] sel, input logic [15:0] prs, input logic [15:0] rl);
        logic [1:0] idx;
        idx = {sel[0], sel[1]};
        return (int'(rl) + 1) << prs[idx*4 +: 4];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, `SWT_RESP_OKAY, "write response");
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic wait_tog(input int k);
        int t0;
        int n;
        t0 = toggles;
        n = 0;
        while (toggles < t0 + k && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        if (toggles < t0 + k) begin
            n_mismatch++;
            $display("[FAIL] %0t toggle wait expired", $time);
        end
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 25);
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end

    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        logic [15:0] rl;
        int          t0, e0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk(pin, 1'b0, "pin after reset");
        chk(irq, 1'b0, "event after reset");
        rd(8'h40);
        chk(rd_resp, 2'h2, "unmapped response");
        chk(rd_data, 32'h0, "unmapped data");
        wr(`SWT_OFF_MODE, 32'hffff_ffff);
        rd(`SWT_OFF_MODE);
        chk(rd_data, 32'h0000_dfcf, "mode fields");
        wr(`SWT_OFF_CLK_EN, 32'h1);
        wr(`SWT_OFF_PRESCALE, {16'h0, prs_cfg});
        wr(`SWT_OFF_OUT_CTRL, 32'h1);
        // Every clock select, zero reload first, random reloads after
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            rl = (i == 0) ? 16'h0 : {13'h0, seed[2:0]};
            wr(`SWT_OFF_MODE, {16'h0, i[1:0], 14'h0});
            wr(`SWT_OFF_RELOAD, {16'h0, rl});
            wr(`SWT_OFF_START, 32'h1);
            wait_tog(3);
            chk(half_len, exp_half(i[1:0], prs_cfg, rl), "half period");
            chk(events, toggles, "event and toggle count");
        end
        // Stop first so no leftover expiry lands in the event count
        wr(`SWT_OFF_START, 32'h0);
        wr(`SWT_OFF_MODE, 32'hc000);
        wr(`SWT_OFF_RELOAD, 32'h100);
        wr(`SWT_OFF_START, 32'h1);
        e0 = events;
        rd(`SWT_OFF_COUNT);
        chk(rd_data > 32'hfe && rd_data < 32'h101, 1'b1, "count after start");
        chk(events, e0, "no event at start");
        wr(`SWT_OFF_MODE, 32'hc001);
        e0 = events;
        t0 = toggles;
        wr(`SWT_OFF_START, 32'h1);
        repeat (4) @(posedge aclk);
        chk(events, e0 + 1, "event at start");
        chk(toggles, t0 + 1, "toggle at start");
        rd(`SWT_OFF_STATUS);
        chk(rd_data[1], 1'b1, "event flag set");
        wr(`SWT_OFF_STATUS, 32'h2);
        rd(`SWT_OFF_STATUS);
        chk(rd_data[1], 1'b0, "event flag cleared");
        wr(`SWT_OFF_OUT_CTRL, 32'h3);
        t0 = toggles;
        e0 = events;
        wr(`SWT_OFF_MODE, 32'h0);
        wr(`SWT_OFF_RELOAD, 32'h3);
        wr(`SWT_OFF_START, 32'h1);
        repeat (60) @(posedge aclk);
        chk(toggles, t0, "slave mode holds pin");
        chk(events > e0 + 4, 1'b1, "events keep coming");
        wr(`SWT_OFF_OUT_CTRL, 32'h0);
        wr(`SWT_OFF_OUT_CTRL, 32'h4);
        repeat (2) @(posedge aclk);
        chk(pin, 1'b1, "software level high");
        rd(`SWT_OFF_OUT_CTRL);
        chk(rd_data, 32'h4, "level read back");
        wr(`SWT_OFF_OUT_CTRL, 32'h0);
        repeat (2) @(posedge aclk);
        chk(pin, 1'b0, "software level low");
        wr(`SWT_OFF_OUT_CTRL, 32'h1);
        wait_tog(3);
        chk(half_len, exp_half(2'b00, prs_cfg, 16'h3), "timer drives pin again");
        wr(`SWT_OFF_CLK_EN, 32'h0);
        repeat (2) @(posedge aclk);
        t0 = toggles;
        repeat (50) @(posedge aclk);
        chk(toggles, t0, "gated clock stops");
        wr(`SWT_OFF_START, 32'h1);
        rd(`SWT_OFF_STATUS);
        chk(rd_data[0], 1'b0, "no run while gated");
        results();
    end
endmodule
`default_nettype wire
